// File: core/fspc_pkg.sv
/*
 * fspc_pkg: constants for the flash self-program control block.
 * assumes: one 200 MHz clock, apb register access, 32-bit data.
 */
package fspc_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [11:0] FSPC_CSR_OFF = 12'h000;   // control/status
    localparam logic [11:0] FSPC_ZPTR_OFF = 12'h004;  // address pointer
    localparam logic [11:0] FSPC_DATA_OFF = 12'h008;  // r0 operand
    localparam logic [11:0] FSPC_INSN_OFF = 12'h00c;  // instruction issue
    localparam logic [11:0] FSPC_RDAT_OFF = 12'h010;  // load-program result
    localparam logic [11:0] FSPC_STAT_OFF = 12'h014;  // lock bits / status
    // -----------------------------------------------------------------
    // control/status field positions
    // -----------------------------------------------------------------
    localparam int FSPC_IE_BIT = 7;
    localparam int FSPC_BUSY_BIT = 6;
    localparam logic [4:0] FSPC_CMD_LOAD = 5'h01;
    localparam logic [4:0] FSPC_CMD_ERASE = 5'h03;
    localparam logic [4:0] FSPC_CMD_WRITE = 5'h05;
    localparam logic [4:0] FSPC_CMD_LOCK = 5'h09;
    localparam logic [4:0] FSPC_CMD_RDEN = 5'h11;
    // insn register: bit0 store-program, bit1 load-program
    localparam int FSPC_INSN_ST_BIT = 0;
    localparam int FSPC_INSN_LD_BIT = 1;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam logic [2:0] FSPC_ST_WIN = 3'h4;  // store window, cycles
    localparam logic [2:0] FSPC_LD_WIN = 3'h3;  // load window, cycles
    localparam logic [7:0] FSPC_LOCK_RST = 8'hff; // all unprogrammed
    typedef enum {FSPC_IDLE, FSPC_ARMED, FSPC_PROG} fspc_state_e;
endpackage

// File: core/fspc_ctrl.sv
/*
 * fspc_ctrl: self-program sequencer with apb register slave.
 * assumes: the core issues store/load-program through the insn register,
 * and the flash array reports completion on op_done.
 */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - halting-section programming stalls the cpu
// - lock bits cleared only by chip erase or reset
// - memory lock modes never gate self-program
// - app protect patterns gate buffer loads and writes
// - app patterns 00/01 suppress interrupts
// - boot protect patterns gate buffer loads and writes
// - boot patterns 00/01 suppress interrupts
// - reset vector chosen by boot reset fuse
// - software cannot alter fuses
// - ready irq while enable bit clear
// - concurrent-section programming sets busy bit
// - busy clears on read-enable or buffer load
// - read-enable refused while programming
// - read-enable aborts buffer load
// - lock-set programs lock bits from r0
// - lock-set load returns lock or fuse
// - page write from buffer, high z
// - page erase at high z page
// - enable alone loads one buffer word
// - invalid command patterns ignored
// - target address latched at start
// - buffer cleared after write, rden, reset
// - eeprom write blocks programming and fuse reads
module fspc_ctrl
    import fspc_pkg::*;
#(
    parameter int WORD_BITS = 5,          // word index bits in z
    parameter int PAGE_BITS = 10,         // page index bits
    parameter logic [15:0] BOOT_START = 16'h7000, // boot area start, word
    parameter logic [15:0] HALT_START = 16'h7000  // halting section start
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_done,            // array finished erase/write
    input wire logic eeprom_busy,
    input wire logic chip_erase,         // external full erase
    input wire logic global_ie,
    input wire logic exec_in_boot,       // cpu runs from boot area
    input wire logic vectors_in_boot,
    input wire logic boot_reset_fuse,
    input wire logic [7:0] fuse_lo,
    input wire logic [7:0] fuse_hi,
    output logic cpu_stall,
    output logic ready_irq,
    output logic irq_suppress,
    output logic [15:0] reset_vector,
    output logic erase_start,
    output logic write_start,
    output logic [PAGE_BITS-1:0] page_index_bits,
    output logic [15:0] buf_word_data,
    output logic [WORD_BITS-1:0] word_index_bits,
    output logic buf_word_we
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    localparam int NW = 1 << WORD_BITS;
    fspc_state_e st_r, st_nxt;
    logic [4:0] cmd_r, cmd_nxt;          // low five control bits
    logic ie_r, ie_nxt;
    logic busy_r, busy_nxt;              // concurrent section busy
    logic [2:0] win_r, win_nxt;          // arming window count
    logic [15:0] z_r, z_nxt;
    logic [15:0] d_r, d_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic [7:0] lock_r, lock_nxt;        // boot lock bits, 1=unprog
    logic [NW-1:0] used_r, used_nxt;     // buffer words written
    logic halt_op_r, halt_op_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic erase_nxt, write_nxt, we_nxt, stall_nxt, irq_nxt, sup_nxt;
    logic [PAGE_BITS-1:0] page_nxt;
    logic [WORD_BITS-1:0] word_nxt;
    logic [15:0] vec_nxt;
    logic [1:0] app_p, boot_p;
    logic setup, acc, st_req, ld_req, tgt_boot, tgt_halt;
    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb
    begin
        setup = psel && !penable;
        acc = psel && penable && pready;
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        ie_nxt = ie_r;
        busy_nxt = busy_r;
        win_nxt = win_r;
        z_nxt = z_r;
        d_nxt = d_r;
        rd_nxt = rd_r;
        lock_nxt = lock_r;
        used_nxt = used_r;
        halt_op_nxt = halt_op_r;
        erase_nxt = 1'b0;
        write_nxt = 1'b0;
        we_nxt = 1'b0;
        page_nxt = page_index_bits;
        word_nxt = word_index_bits;
        prdata_nxt = prdata;
        pready_nxt = setup;              // no wait state; pready rises in the first access cycle
        pslverr_nxt = 1'b0;
        st_req = acc && pwrite && paddr == FSPC_INSN_OFF && pwdata[FSPC_INSN_ST_BIT];
        ld_req = acc && pwrite && paddr == FSPC_INSN_OFF && pwdata[FSPC_INSN_LD_BIT];
        app_p = lock_r[3:2];
        boot_p = lock_r[5:4];
        tgt_boot = z_r[15:1] >= BOOT_START[15:1];
        tgt_halt = z_r[15:1] >= HALT_START[15:1];
        if (setup && !pwrite)
        begin
            unique case (paddr)
                FSPC_CSR_OFF: prdata_nxt = {24'h0, ie_r, busy_r, 1'b0, cmd_r};
                FSPC_ZPTR_OFF: prdata_nxt = {16'h0, z_r};
                FSPC_DATA_OFF: prdata_nxt = {16'h0, d_r};
                FSPC_RDAT_OFF: prdata_nxt = {24'h0, rd_r};
                FSPC_STAT_OFF: prdata_nxt = {24'h0, lock_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
        if (setup)
        begin
            pslverr_nxt = !(paddr inside {FSPC_CSR_OFF, FSPC_ZPTR_OFF, FSPC_DATA_OFF,
                FSPC_INSN_OFF, FSPC_RDAT_OFF, FSPC_STAT_OFF});
        end
        // window countdown clears all command bits on expiry
        if (st_r == FSPC_ARMED)
        begin
            win_nxt = win_r - 3'h1;
            if (win_r == 3'h1)
            begin
                cmd_nxt = 5'h0;
                st_nxt = FSPC_IDLE;
            end
        end
        if (acc && pwrite && paddr == FSPC_ZPTR_OFF) z_nxt = pwdata[15:0];
        if (acc && pwrite && paddr == FSPC_DATA_OFF) d_nxt = pwdata[15:0];
        if (acc && pwrite && paddr == FSPC_CSR_OFF)
        begin
            ie_nxt = pwdata[FSPC_IE_BIT];
            // only five patterns arm; others ignored, eeprom write blocks
            if (st_r != FSPC_PROG && !eeprom_busy && pwdata[4:0] inside
                {FSPC_CMD_LOAD, FSPC_CMD_ERASE, FSPC_CMD_WRITE,
                 FSPC_CMD_LOCK, FSPC_CMD_RDEN})
            begin
                cmd_nxt = pwdata[4:0];
                win_nxt = FSPC_ST_WIN;
                st_nxt = FSPC_ARMED;
                if (pwdata[4:0] == FSPC_CMD_RDEN)
                    used_nxt = '0;
            end
        end
        // load-program read of lock or fuse bits
        if (ld_req && st_r == FSPC_ARMED && cmd_r == FSPC_CMD_LOCK
            && win_r > FSPC_ST_WIN - FSPC_LD_WIN && !eeprom_busy)
        begin
            rd_nxt = z_r[0] ? (z_r[1] ? fuse_hi : lock_r) : fuse_lo;
            cmd_nxt = 5'h0;
            st_nxt = FSPC_IDLE;
        end
        else if (st_req && st_r == FSPC_ARMED)
        begin
            st_nxt = FSPC_IDLE;
            cmd_nxt = 5'h0;
            unique case (cmd_r)
                FSPC_CMD_LOAD:
                begin
                    busy_nxt = 1'b0;
                    if (!used_r[z_r[WORD_BITS:1]] && (tgt_boot ? boot_p[0] : app_p[0]))
                    begin
                        used_nxt[z_r[WORD_BITS:1]] = 1'b1;
                        word_nxt = z_r[WORD_BITS:1];
                        we_nxt = 1'b1;
                    end
                end
                FSPC_CMD_ERASE, FSPC_CMD_WRITE:
                begin
                    // app or boot lock bits gate writes by target, low bit programmed=blocked
                    if (exec_in_boot && (tgt_boot ? boot_p[0] : app_p[0]))
                    begin
                        page_nxt = z_r[WORD_BITS+PAGE_BITS:WORD_BITS+1];
                        erase_nxt = cmd_r == FSPC_CMD_ERASE;
                        write_nxt = cmd_r == FSPC_CMD_WRITE;
                        cmd_nxt = cmd_r;
                        halt_op_nxt = tgt_halt;
                        busy_nxt = busy_r | !tgt_halt;
                        st_nxt = FSPC_PROG;
                    end
                end
                FSPC_CMD_LOCK:
                    lock_nxt = lock_r & {2'b11, d_r[5:2], 2'b11};
                default:
                begin
                    busy_nxt = 1'b0;
                    used_nxt = '0;
                end
            endcase
        end
        if (st_r == FSPC_PROG && op_done)
        begin
            if (cmd_r == FSPC_CMD_WRITE) used_nxt = '0;
            cmd_nxt = 5'h0;
            halt_op_nxt = 1'b0;
            st_nxt = FSPC_IDLE;
        end
        if (chip_erase) lock_nxt = FSPC_LOCK_RST;
        stall_nxt = (st_nxt == FSPC_PROG) && halt_op_nxt;
        irq_nxt = ie_nxt && global_ie && !cmd_nxt[0];
        sup_nxt = (!app_p[1] && vectors_in_boot && !exec_in_boot)
            || (!boot_p[1] && !vectors_in_boot && exec_in_boot);
        vec_nxt = boot_reset_fuse ? 16'h0000 : BOOT_START;
    end
    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= FSPC_IDLE;
            cmd_r <= 5'h0;
            ie_r <= 1'b0;
            busy_r <= 1'b0;
            win_r <= 3'h0;
            z_r <= 16'h0;
            d_r <= 16'h0;
            rd_r <= 8'h0;
            lock_r <= FSPC_LOCK_RST;
            used_r <= '0;
            halt_op_r <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            erase_start <= 1'b0;
            write_start <= 1'b0;
            buf_word_we <= 1'b0;
            page_index_bits <= '0;
            word_index_bits <= '0;
            buf_word_data <= 16'h0;
            cpu_stall <= 1'b0;
            ready_irq <= 1'b0;
            irq_suppress <= 1'b0;
            reset_vector <= 16'h0;
        end
        else
        begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            ie_r <= ie_nxt;
            busy_r <= busy_nxt;
            win_r <= win_nxt;
            z_r <= z_nxt;
            d_r <= d_nxt;
            rd_r <= rd_nxt;
            lock_r <= lock_nxt;
            used_r <= used_nxt;
            halt_op_r <= halt_op_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            erase_start <= erase_nxt;
            write_start <= write_nxt;
            buf_word_we <= we_nxt;
            page_index_bits <= page_nxt;
            word_index_bits <= word_nxt;
            buf_word_data <= d_r;
            cpu_stall <= stall_nxt;
            ready_irq <= irq_nxt;
            irq_suppress <= sup_nxt;
            reset_vector <= vec_nxt;
        end
    end
    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_window_expiry: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == FSPC_ARMED && win_r == 3'h1 && !st_req && !ld_req
         && !(acc && pwrite && paddr == FSPC_CSR_OFF)) |=> cmd_r == 5'h0)
        else $error("command bits survived window");
    a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        (ie_r && $past(global_ie) && !cmd_r[0]) |-> ready_irq)
        else $error("ready irq missing");
    a_halt_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == FSPC_PROG && halt_op_r) |-> cpu_stall)
        else $error("cpu not stalled");
    a_busy_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == FSPC_PROG && !halt_op_r) |-> busy_r)
        else $error("busy not set");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (pready && paddr == FSPC_CSR_OFF && !pwrite) |-> !prdata[5])
        else $error("reserved bit set");
    a_lock_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        !chip_erase |=> (lock_r & ~$past(lock_r)) == 8'h0)
        else $error("lock bit cleared");
    a_vector_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> reset_vector == ($past(boot_reset_fuse) ? 16'h0000 : BOOT_START))
        else $error("bad reset vector");
    a_prog_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r == FSPC_PROG) |-> cmd_r[0])
        else $error("enable dropped mid op");
    c_erase: cover property (@(posedge mclk) disable iff (!rst_n) erase_start);
    c_write: cover property (@(posedge mclk) disable iff (!rst_n) write_start);
    c_load: cover property (@(posedge mclk) disable iff (!rst_n) buf_word_we);
endmodule
`default_nettype wire

// File: verification/fspc_flash_model.sv
/*
 * fspc_flash_model: flash array stand-in that answers erase and write starts.
 * assumes: erase_start and write_start are one-cycle pulses on mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic erase_start,
    input wire logic write_start,
    input wire logic [7:0] op_cycles,
    output logic op_done
);
    // ------------------------------------
    // busy countdown
    // ------------------------------------
    logic [7:0] left_r; // cycles to completion, 0 when idle
    // op_cycles picks prompt or slow completion; no early done pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_r <= 8'h00;
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= (left_r == 8'h01); // single-cycle done
            if (erase_start || write_start)
                left_r <= op_cycles;
            else if (left_r != 8'h00)
                left_r <= left_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_flash_self_program_control.sv
/*
 * tb_flash_self_program_control: self-checking bench for fspc_ctrl.
 * assumes: apb slave with no wait states, flash model on op_done.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_program_control import fspc_pkg::*;;
    // ------------------------------------
    // signals
    // ------------------------------------
    localparam logic [15:0] BOOT = 16'h7000; // boot area start, word
    logic mclk, rst_n, psel, penable, pwrite, op_done, eeprom_busy, chip_erase, global_ie;
    logic exec_in_boot, vectors_in_boot, boot_reset_fuse, pready, pslverr, err_v;
    logic cpu_stall, ready_irq, irq_suppress, erase_start, write_start, buf_word_we, stalled;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic [7:0] fuse_lo, fuse_hi, op_cycles, lock_e;
    logic [15:0] reset_vector, buf_word_data, z, bd;
    logic [9:0] page_index_bits, pg;
    logic [4:0] word_index_bits, wd;
    int fails = 0, tests_run = 0, n_er = 0, n_wr = 0, n_ld = 0, cyc = 0;
    fspc_ctrl #(.WORD_BITS(5), .PAGE_BITS(10), .BOOT_START(BOOT), .HALT_START(BOOT)) uut (
        .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .op_done, .eeprom_busy, .chip_erase, .global_ie, .exec_in_boot,
        .vectors_in_boot, .boot_reset_fuse, .fuse_lo, .fuse_hi, .cpu_stall, .ready_irq,
        .irq_suppress, .reset_vector, .erase_start, .write_start, .page_index_bits,
        .buf_word_data, .word_index_bits, .buf_word_we);
    fspc_flash_model flash (.mclk, .rst_n, .erase_start, .write_start, .op_cycles, .op_done);
    // ------------------------------------
    // clock, timeout, pulse monitor
    // ------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // pulses are one cycle wide; sampled on the falling edge, where outputs
    // are settled and the main sequence never races the captured copies
    always @(negedge mclk)
    begin
        cyc++;
        if (erase_start === 1'b1) n_er++;
        if (write_start === 1'b1) n_wr++;
        if ((erase_start | write_start) === 1'b1) pg = page_index_bits;
        if (buf_word_we === 1'b1)
        begin
            n_ld++;
            wd = word_index_bits;
            bd = buf_word_data;
        end
        if (cpu_stall === 1'b1) stalled = 1'b1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    // ------------------------------------
    // helpers
    // ------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [9:0] pg_of(input logic [15:0] a);
        return a[15:6]; // page sits above the word bits
    endfunction
    function automatic logic [7:0] lock_after(input logic [7:0] o, input logic [7:0] r0);
        return o & (r0 | 8'hc3); // only bits 5..2 can be programmed
    endfunction
    task automatic stop_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // request held until pready; caller releases or chains the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
    endtask
    task automatic rel();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        rel();
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        rel();
    endtask
    // csr write chained straight into the instruction, inside the window
    task automatic cmd(input logic [7:0] c, input logic [1:0] insn);
        apb(1'b1, FSPC_CSR_OFF, {24'h0, c});
        apb(1'b1, FSPC_INSN_OFF, {30'h0, insn});
        rel();
    endtask
    task automatic wait_done();
        for (int i = 0; i < 100; i++)
        begin
            rd(FSPC_CSR_OFF);
            if (rd_v[0] === 1'b0) break;
        end
    endtask
    task automatic rb(input logic [1:0] zs, input logic [7:0] e);
        wr(FSPC_ZPTR_OFF, {30'h0, zs});
        cmd(8'h09, 2'b10);
        rd(FSPC_RDAT_OFF);
        chk(rd_v[7:0], e);
    endtask
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial
    begin
        {psel, penable, pwrite, rst_n, eeprom_busy, chip_erase, vectors_in_boot} = 7'h00;
        {global_ie, exec_in_boot, boot_reset_fuse, stalled} = 4'he;
        paddr = 12'h000;
        pwdata = 32'h0;
        op_cycles = 8'h1e;
        seed = lfsr(32'h052cc186);
        fuse_lo = seed[7:0];
        fuse_hi = seed[15:8];
        lock_e = FSPC_LOCK_RST;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(reset_vector, 16'h0000);
        rd(FSPC_CSR_OFF);
        chk(rd_v[5:0], 6'h00);
        rd(12'h040);
        chk(err_v, 1'b1);
        rb(2'b00, fuse_lo);
        rb(2'b01, lock_e);
        rb(2'b11, fuse_hi);
        // concurrent-section erase, refused re-enable, then re-enable
        wr(FSPC_ZPTR_OFF, 32'h0100);
        cmd(8'h03, 2'b01);
        rd(FSPC_CSR_OFF);
        chk(rd_v[6], 1'b1);
        chk(rd_v[0], 1'b1);
        chk(cpu_stall, 1'b0);
        cmd(8'h11, 2'b01);
        rd(FSPC_CSR_OFF);
        chk(rd_v[6], 1'b1);
        wait_done();
        chk(n_er, 1);
        chk(pg, pg_of(16'h0100));
        chk(rd_v[6], 1'b1);
        cmd(8'h11, 2'b01);
        rd(FSPC_CSR_OFF);
        chk(rd_v[6], 1'b0);
        // halting-section erase with the ready interrupt armed
        wr(FSPC_ZPTR_OFF, 32'hfe00);
        cmd(8'h83, 2'b01);
        chk(ready_irq, 1'b0);
        wait_done();
        chk(stalled, 1'b1);
        chk(rd_v[6], 1'b0);
        repeat (2) @(posedge mclk);
        chk(ready_irq, 1'b1);
        // random buffer loads; z bit 0 is random and must be ignored
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            z = {10'h005, 3'h0, i[1:0], seed[0]};
            wr(FSPC_ZPTR_OFF, {16'h0, z});
            wr(FSPC_DATA_OFF, {16'h0, seed[31:16]});
            cmd(8'h01, 2'b01);
            chk(wd, z[5:1]);
            chk(bd, seed[31:16]);
            rd(FSPC_CSR_OFF);
            chk(rd_v[0], 1'b0);
        end
        chk(n_ld, 4);
        // page write; z reused mid-operation; buffer load then clears busy
        op_cycles <= 8'h06;
        wr(FSPC_ZPTR_OFF, 32'h0140);
        cmd(8'h05, 2'b01);
        wr(FSPC_ZPTR_OFF, 32'hffff);
        wait_done();
        chk(n_wr, 1);
        chk(pg, pg_of(16'h0140));
        chk(rd_v[6], 1'b1);
        cmd(8'h01, 2'b01);
        rd(FSPC_CSR_OFF);
        chk(rd_v[6], 1'b0);
        // window runs out; store afterwards does nothing
        wr(FSPC_CSR_OFF, 32'h05);
        repeat (8) @(posedge mclk);
        rd(FSPC_CSR_OFF);
        chk(rd_v[4:0], 5'h00);
        wr(FSPC_INSN_OFF, 32'h1);
        repeat (4) @(posedge mclk);
        chk(n_wr, 1);
        foreach (fuse_hi[k])
        begin
            if (k < 4)
            begin
                wr(FSPC_CSR_OFF, {24'h0, 8'h07 << k});
                rd(FSPC_CSR_OFF);
                chk(rd_v[5:0], 6'h00);
            end
        end
        // lock set to app pattern 00, then interrupt and write gating
        wr(FSPC_DATA_OFF, 32'hf3);
        cmd(8'h09, 2'b01);
        wait_done();
        lock_e = lock_after(lock_e, 8'hf3);
        rb(2'b01, lock_e);
        rb(2'b00, fuse_lo);
        vectors_in_boot <= 1'b1;
        exec_in_boot <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(irq_suppress, 1'b1);
        exec_in_boot <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(irq_suppress, 1'b0);
        wr(FSPC_ZPTR_OFF, 32'h0100);
        cmd(8'h03, 2'b01);
        repeat (10) @(posedge mclk);
        chk(n_er, 2);
        chip_erase <= 1'b1;
        @(posedge mclk);
        chip_erase <= 1'b0;
        rb(2'b01, FSPC_LOCK_RST);
        eeprom_busy <= 1'b1;
        cmd(8'h03, 2'b01);
        repeat (10) @(posedge mclk);
        chk(n_er, 2);
        eeprom_busy <= 1'b0;
        // second reset with the boot reset fuse programmed
        boot_reset_fuse <= 1'b0;
        rst_n <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(reset_vector, BOOT);
        stop_test();
    end
endmodule
`default_nettype wire
